// ==== rtc_mfp_pkg.sv ====
`default_nettype none
package rtc_mfp_pkg;

	// register addresses on the byte-wide register port
	localparam logic [7:0] ADDR_OUTPUT_CONTROL  = 8'h07;
	localparam logic [7:0] ADDR_OSCILLATOR_TRIM = 8'h08;
	localparam logic [7:0] ADDR_ALARM0_WEEKDAY  = 8'h0D;
	localparam logic [7:0] ADDR_ALARM1_WEEKDAY  = 8'h14;

	// values after reset
	localparam logic [7:0] RESET_OUTPUT_CONTROL  = 8'h80;
	localparam logic [7:0] RESET_OSCILLATOR_TRIM = 8'h00;
	localparam logic [7:0] RESET_ALARM_WEEKDAY   = 8'h01;

	// field positions
	localparam int ALARM_FLAG_BIT     = 3;
	localparam int ALARM_POLARITY_BIT = 7;

	// timebase figures
	localparam int        PRESCALE_WIDTH    = 15;
	localparam int        SQ_TAP_1HZ        = 14;
	localparam int        SQ_TAP_4096HZ     = 2;
	localparam int        SQ_TAP_8192HZ     = 1;
	localparam int        SQ_TAP_64HZ       = 8;
	localparam int        COARSE_ADJ_WIDTH  = 8;
	localparam logic [5:0] SECONDS_PER_MINUTE = 6'h3B;
	localparam int        TRIM_PENDING_WIDTH = 8;

	typedef enum logic [1:0] {
		FREQ_1HZ    = 2'b00,
		FREQ_4096HZ = 2'b01,
		FREQ_8192HZ = 2'b10,
		FREQ_32768HZ = 2'b11
	} square_freq_t;

	typedef enum logic [1:0] {
		MODE_GENERAL = 2'b00,
		MODE_ALARM   = 2'b01,
		MODE_SQUARE  = 2'b10
	} pin_mode_t;

	typedef struct packed {
		logic         general_output_level;
		logic         square_wave_enable;
		logic         alarm1_enable;
		logic         alarm0_enable;
		logic         external_clock_select;
		logic         coarse_trim_enable;
		square_freq_t square_freq_select;
	} output_control_t;

	typedef struct packed {
		logic       trim_sign;
		logic [6:0] trim_magnitude;
	} oscillator_trim_t;

	typedef struct packed {
		logic [7:0] addr;
		logic       write;
		logic       read;
		logic [7:0] wdata;
	} reg_req_t;

endpackage
`default_nettype wire

// ==== rtc_output_mux_and_trim.sv ====
`default_nettype none
module rtc_output_mux_and_trim
	import rtc_mfp_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	// register port
	input  wire reg_req_t   reg_req_i,
	output var  logic [7:0] reg_rdata_o,
	// timebase sources and supply state
	input  wire logic       crystal_osc_i,
	input  wire logic       crystal_input_pin_i,
	input  wire logic       on_backup_i,
	// alarm match events from the comparators
	input  wire logic       alarm0_match_i,
	input  wire logic       alarm1_match_i,
	// open-drain multi-function pin
	output var  logic       multi_function_pin_o,
	output var  logic       multi_function_pin_oe_o,
	// status
	output var  logic       alarm0_flag_o,
	output var  logic       alarm1_flag_o
);

	////////////////////////////////////////////////////////////////////////
	output_control_t                  ctrl;
	oscillator_trim_t                 trim;
	logic [7:0]                       weekday0;
	logic [7:0]                       weekday1;
	logic                             alarm0_flag;
	logic                             alarm1_flag;
	logic                             wr_ctrl;
	logic                             wr_trim;
	logic                             wr_wk0;
	logic                             wr_wk1;

	assign wr_ctrl = reg_req_i.write && (reg_req_i.addr == ADDR_OUTPUT_CONTROL);
	assign wr_trim = reg_req_i.write && (reg_req_i.addr == ADDR_OSCILLATOR_TRIM);
	assign wr_wk0  = reg_req_i.write && (reg_req_i.addr == ADDR_ALARM0_WEEKDAY);
	assign wr_wk1  = reg_req_i.write && (reg_req_i.addr == ADDR_ALARM1_WEEKDAY);

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ctrl <= output_control_t'(RESET_OUTPUT_CONTROL);
		end else if (wr_ctrl) begin
			ctrl <= output_control_t'(reg_req_i.wdata);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			trim <= oscillator_trim_t'(RESET_OSCILLATOR_TRIM);
		end else if (wr_trim) begin
			trim <= oscillator_trim_t'(reg_req_i.wdata);
		end
	end

	// polarity bit is shared: a write to either weekday register updates both copies
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			weekday0 <= RESET_ALARM_WEEKDAY;
			weekday1 <= RESET_ALARM_WEEKDAY;
		end else begin
			if (wr_wk0) begin
				weekday0 <= reg_req_i.wdata;
				weekday1[ALARM_POLARITY_BIT] <= reg_req_i.wdata[ALARM_POLARITY_BIT];
			end
			if (wr_wk1) begin
				weekday1 <= reg_req_i.wdata;
				weekday0[ALARM_POLARITY_BIT] <= reg_req_i.wdata[ALARM_POLARITY_BIT];
			end
		end
	end

	// flag bit written by software is ignored; a match in the clearing cycle wins
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			alarm0_flag <= 1'b0;
			alarm1_flag <= 1'b0;
		end else begin
			if (alarm0_match_i) begin
				alarm0_flag <= 1'b1;
			end else if (wr_wk0) begin
				alarm0_flag <= 1'b0;
			end
			if (alarm1_match_i) begin
				alarm1_flag <= 1'b1;
			end else if (wr_wk1) begin
				alarm1_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_req_i.read) begin
			case (reg_req_i.addr)
				ADDR_OUTPUT_CONTROL:  reg_rdata_o <= ctrl;
				ADDR_OSCILLATOR_TRIM: reg_rdata_o <= trim;
				ADDR_ALARM0_WEEKDAY: begin
					reg_rdata_o <= {weekday0[7:4], alarm0_flag, weekday0[2:0]};
				end
				ADDR_ALARM1_WEEKDAY: begin
					reg_rdata_o <= {weekday1[7:4], alarm1_flag, weekday1[2:0]};
				end
				default:              reg_rdata_o <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			alarm0_flag_o <= 1'b0;
			alarm1_flag_o <= 1'b0;
		end else begin
			alarm0_flag_o <= alarm0_flag;
			alarm1_flag_o <= alarm1_flag;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// timebase: oscillator level sampled, rising edge is one tick
	logic osc_level;
	logic osc_level_d;
	logic osc_tick;

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			osc_level   <= 1'b0;
			osc_level_d <= 1'b0;
		end else begin
			osc_level   <= ctrl.external_clock_select ? crystal_input_pin_i
				: crystal_osc_i;
			osc_level_d <= osc_level;
		end
	end

	assign osc_tick = osc_level && !osc_level_d;

	////////////////////////////////////////////////////////////////////////
	// trimmed prescaler; trimming never depends on the supply state
	logic [PRESCALE_WIDTH-1:0]     prescale;
	logic [PRESCALE_WIDTH:0]       prescale_sum;
	logic [5:0]                    seconds;
	logic [TRIM_PENDING_WIDTH-1:0] pending;
	logic                          pending_add;
	logic                          sq_mode_d;
	logic                          sq_entry;
	logic                          prescale_wrap;
	logic                          coarse_point;
	logic                          minute_point;
	logic                          adjust_now;
	logic [PRESCALE_WIDTH-1:0]     step;

	assign sq_entry      = ctrl.square_wave_enable && !sq_mode_d;
	// carries, not all-ones matches: a step of two can jump over all ones
	assign prescale_sum  = {1'b0, prescale} + {1'b0, step};
	assign prescale_wrap = osc_tick && prescale_sum[PRESCALE_WIDTH];
	assign coarse_point  = osc_tick
		&& (prescale_sum[COARSE_ADJ_WIDTH] != prescale[COARSE_ADJ_WIDTH]);
	assign minute_point  = prescale_wrap && (seconds == SECONDS_PER_MINUTE);
	assign adjust_now    = (ctrl.coarse_trim_enable ? coarse_point : minute_point)
		&& (trim.trim_magnitude != 7'h00);

	// add: an extra count on each tick; remove: swallow the tick
	always_comb begin
		step = PRESCALE_WIDTH'(1);
		if (pending != '0) begin
			step = pending_add ? PRESCALE_WIDTH'(2) : PRESCALE_WIDTH'(0);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			sq_mode_d <= 1'b0;
		end else begin
			sq_mode_d <= ctrl.square_wave_enable;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			prescale <= '0;
		end else if (sq_entry) begin
			prescale <= '0;
		end else if (osc_tick) begin
			prescale <= prescale + step;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			seconds <= 6'h00;
		end else if (prescale_wrap) begin
			seconds <= (seconds == SECONDS_PER_MINUTE) ? 6'h00 : seconds + 6'h01;
		end
	end

	// a new trim value drops any adjustment still in progress
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			pending     <= '0;
			pending_add <= 1'b0;
		end else if (wr_trim) begin
			pending     <= '0;
		end else if (adjust_now) begin
			pending     <= {trim.trim_magnitude, 1'b0};
			pending_add <= trim.trim_sign;
		end else if (osc_tick && pending != '0) begin
			pending <= pending - TRIM_PENDING_WIDTH'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output mode selection and pin drive
	pin_mode_t mode;
	logic      square_level;
	logic      alarm_level;
	logic      next_drive_low;
	logic      polarity;

	assign polarity = weekday0[ALARM_POLARITY_BIT];

	always_comb begin
		if (ctrl.square_wave_enable) begin
			mode = MODE_SQUARE;
		end else if (ctrl.alarm0_enable || ctrl.alarm1_enable) begin
			mode = MODE_ALARM;
		end else begin
			mode = MODE_GENERAL;
		end
	end

	always_comb begin
		square_level = prescale[SQ_TAP_64HZ];
		if (!ctrl.coarse_trim_enable) begin
			case (ctrl.square_freq_select)
				FREQ_1HZ:     square_level = prescale[SQ_TAP_1HZ];
				FREQ_4096HZ:  square_level = prescale[SQ_TAP_4096HZ];
				FREQ_8192HZ:  square_level = prescale[SQ_TAP_8192HZ];
				FREQ_32768HZ: square_level = osc_level_d;
				default:      square_level = 1'b1;
			endcase
		end
	end

	always_comb begin
		if (ctrl.alarm0_enable && ctrl.alarm1_enable) begin
			alarm_level = polarity ? (alarm0_flag || alarm1_flag)
				: !(alarm0_flag && alarm1_flag);
		end else if (ctrl.alarm0_enable) begin
			alarm_level = polarity ? alarm0_flag : !alarm0_flag;
		end else begin
			alarm_level = polarity ? alarm1_flag : !alarm1_flag;
		end
	end

	// released pin floats high through the outside pull-up
	always_comb begin
		case (mode)
			MODE_SQUARE:  next_drive_low = !on_backup_i && !square_level;
			MODE_ALARM:   next_drive_low = !alarm_level;
			MODE_GENERAL: begin
				next_drive_low = !on_backup_i && !ctrl.general_output_level;
			end
			default:      next_drive_low = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			multi_function_pin_o    <= 1'b0;
			multi_function_pin_oe_o <= 1'b0;
		end else begin
			multi_function_pin_o    <= 1'b0;
			multi_function_pin_oe_o <= next_drive_low;
		end
	end

endmodule
`default_nettype wire

// ==== rtc_mfp_properties.sv ====
`default_nettype none
module rtc_mfp_properties
	import rtc_mfp_pkg::*;
(
	// clock, reset, register port
	input wire logic     clk_i,
	input wire logic     rst_b_i,
	input wire reg_req_t reg_req_i,
	// supply and alarm events
	input wire logic     on_backup_i,
	input wire logic     alarm0_match_i,
	// pin and flags
	input wire logic     multi_function_pin_o,
	input wire logic     multi_function_pin_oe_o,
	input wire logic     alarm0_flag_o,
	input wire logic     alarm1_flag_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ctrl_shadow;
	logic       pol_shadow;
	wire        wr = reg_req_i.write;
	wire        clr0 = wr && reg_req_i.addr == ADDR_ALARM0_WEEKDAY;
	wire        wk = clr0 || (wr && reg_req_i.addr == ADDR_ALARM1_WEEKDAY);
	wire  [2:0] mode = ctrl_shadow[6:4];
	wire        oe = multi_function_pin_oe_o;
	wire        f0 = alarm0_flag_o;
	wire        f1 = alarm1_flag_o;
	// mirror of written mode bits; the pin mode is not visible at the ports
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ctrl_shadow <= RESET_OUTPUT_CONTROL;
			pol_shadow <= RESET_ALARM_WEEKDAY[ALARM_POLARITY_BIT];
		end else begin
			if (wr && reg_req_i.addr == ADDR_OUTPUT_CONTROL)
				ctrl_shadow <= reg_req_i.wdata;
			if (wk)
				pol_shadow <= reg_req_i.wdata[ALARM_POLARITY_BIT];
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	////////////////////////////////////////
	property p_open_drain;
		multi_function_pin_o == 1'b0;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("pin data high");
	property p_set0;
		alarm0_match_i |-> ##[1:2] f0;
	endproperty
	a_set0: assert property (p_set0) else $error("flag not set");
	property p_clear0;
		clr0 && !alarm0_match_i ##1 !alarm0_match_i |-> ##1 !f0;
	endproperty
	a_clear0: assert property (p_clear0) else $error("flag not cleared");
	property p_general;
		mode == 3'b000 && !on_backup_i |=> oe == !$past(ctrl_shadow[7]);
	endproperty
	a_general: assert property (p_general) else $error("general level wrong");
	property p_backup_gpo;
		mode == 3'b000 && on_backup_i |=> !oe;
	endproperty
	a_backup_gpo: assert property (p_backup_gpo) else $error("driven on backup");
	property p_backup_square;
		ctrl_shadow[6] && on_backup_i |=> !oe;
	endproperty
	a_backup_square: assert property (p_backup_square) else $error("square on backup");
	property p_single;
		mode == 3'b001 && $stable(mode) && $stable(pol_shadow) && $stable(f0)
			|-> oe == (pol_shadow ? !f0 : f0);
	endproperty
	a_single: assert property (p_single) else $error("single alarm wrong");
	property p_dual;
		mode == 3'b011 && $stable(mode) && $stable(pol_shadow) && $stable({f0, f1})
			|-> oe == (pol_shadow ? !(f0 || f1) : f0 && f1);
	endproperty
	a_dual: assert property (p_dual) else $error("dual alarm wrong");
	c_alarm: cover property (mode == 3'b001 && alarm0_match_i);
	c_dual: cover property (mode == 3'b011 && f0 && f1);
	c_square_backup: cover property (ctrl_shadow[6] && on_backup_i);
endmodule
bind rtc_output_mux_and_trim rtc_mfp_properties rtc_mfp_properties_inst (.clk_i, .rst_b_i,
	.reg_req_i, .on_backup_i, .alarm0_match_i, .multi_function_pin_o,
	.multi_function_pin_oe_o, .alarm0_flag_o, .alarm1_flag_o);
`default_nettype wire

// ==== host_pin_monitor.sv ====
`default_nettype none
module host_pin_monitor (
	// clock
	input  wire logic        clk_i,
	// open-drain pin
	input  wire logic        pin_i,
	input  wire logic        pin_oe_i,
	// edge counting
	input  wire logic        clear_i,
	output var  logic        level_o,
	output var  logic [15:0] edges_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last;
	// pull-up supplies the high level whenever the pin is released
	assign level_o = pin_oe_i ? pin_i : 1'b1;
	always_ff @(posedge clk_i) begin
		last <= level_o;
		if (clear_i)
			edges_o <= 16'h0000;
		else if (level_o && !last)
			edges_o <= edges_o + 16'h0001;
	end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`default_nettype none
module tb_top import rtc_mfp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i, rst_b_i, on_backup_i, alarm0_match_i, alarm1_match_i, clr, level;
	logic        multi_function_pin_o, multi_function_pin_oe_o, alarm0_flag_o, alarm1_flag_o;
	reg_req_t    reg_req_i;
	logic [7:0]  reg_rdata_o, n;
	logic [3:0]  ph = 4'h0;
	logic [15:0] edges;
	int          miscompares = 0, n_tests = 0, cyc = 0;
	// oscillator period 8 clocks, external source 16 clocks
	wire         crystal_osc_i = ph[2];
	wire         crystal_input_pin_i = ph[3];
	rtc_output_mux_and_trim rtc_output_mux_and_trim_inst (.clk_i, .rst_b_i, .reg_req_i,
		.reg_rdata_o, .crystal_osc_i, .crystal_input_pin_i, .on_backup_i, .alarm0_match_i,
		.alarm1_match_i, .multi_function_pin_o, .multi_function_pin_oe_o, .alarm0_flag_o,
		.alarm1_flag_o);
	host_pin_monitor host_pin_monitor_inst (.clk_i, .pin_i(multi_function_pin_o),
		.pin_oe_i(multi_function_pin_oe_o), .clear_i(clr), .level_o(level), .edges_o(edges));
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	always @(negedge clk_i) ph <= ph + 4'h1;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 70000) begin
			miscompares++;
			report_and_stop();
		end
	end
	////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		reg_req_i <= '{a, 1'b1, 1'b0, d};
		@(negedge clk_i);
		reg_req_i.write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_i);
		reg_req_i <= '{a, 1'b0, 1'b1, 8'h00};
		@(negedge clk_i);
		reg_req_i.read <= 1'b0;
		@(negedge clk_i);
		chk(reg_rdata_o, exp);
	endtask
	task automatic pin(input logic e);
		repeat (4) @(negedge clk_i);
		chk({7'h00, level}, {7'h00, e});
	endtask
	task automatic pulse(input logic one);
		@(negedge clk_i);
		alarm0_match_i <= !one;
		alarm1_match_i <= one;
		@(negedge clk_i);
		alarm0_match_i <= 1'b0;
		alarm1_match_i <= 1'b0;
	endtask
	// window is a whole number of periods, so the edge count is exact
	task automatic count(input logic [7:0] c, input int w);
		wr(ADDR_OUTPUT_CONTROL, c);
		repeat (64) @(negedge clk_i);
		clr <= 1'b1;
		@(negedge clk_i);
		clr <= 1'b0;
		repeat (w) @(negedge clk_i);
		n = edges[7:0];
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		reg_req_i = '0;
		rst_b_i = 1'b0;
		on_backup_i = 1'b0;
		alarm0_match_i = 1'b0;
		alarm1_match_i = 1'b0;
		clr = 1'b0;
		repeat (5) @(negedge clk_i);
		rst_b_i <= 1'b1;
		rd(ADDR_OUTPUT_CONTROL, RESET_OUTPUT_CONTROL);
		rd(ADDR_OSCILLATOR_TRIM, RESET_OSCILLATOR_TRIM);
		rd(ADDR_ALARM1_WEEKDAY, RESET_ALARM_WEEKDAY);
		rd(8'h20, 8'h00);
		pin(1'b1);
		wr(ADDR_OUTPUT_CONTROL, 8'h00);
		pin(1'b0);
		on_backup_i <= 1'b1;
		pin(1'b1);
		on_backup_i <= 1'b0;
		$display("test general done");
		wr(ADDR_ALARM0_WEEKDAY, 8'h00);
		wr(ADDR_OUTPUT_CONTROL, 8'h10);
		pin(1'b1);
		pulse(1'b0);
		pin(1'b0);
		on_backup_i <= 1'b1;
		pin(1'b0);
		on_backup_i <= 1'b0;
		wr(ADDR_ALARM1_WEEKDAY, 8'h80);
		pin(1'b1);
		wr(ADDR_ALARM0_WEEKDAY, 8'h88);
		pin(1'b0);
		chk({7'h00, alarm0_flag_o}, 8'h00);
		rd(ADDR_ALARM0_WEEKDAY, 8'h80);
		wr(ADDR_OUTPUT_CONTROL, 8'h30);
		pin(1'b0);
		pulse(1'b1);
		pin(1'b1);
		chk({7'h00, alarm1_flag_o}, 8'h01);
		wr(ADDR_ALARM0_WEEKDAY, 8'h00);
		pin(1'b1);
		pulse(1'b0);
		pin(1'b0);
		wr(ADDR_OUTPUT_CONTROL, 8'h20);
		pin(1'b0);
		wr(ADDR_ALARM1_WEEKDAY, 8'h00);
		pin(1'b1);
		$display("test alarm done");
		count(8'h73, 512);
		chk(n, 8'h40);
		for (int i = 1; i < 4; i++) begin
			count(8'h40 | 8'(i), 512);
			chk(n, (i == 3) ? 8'h40 : 8'h04 << i);
		end
		count(8'h4B, 512);
		chk(n, 8'h20);
		wr(ADDR_OSCILLATOR_TRIM, 8'hFF);
		count(8'h43, 512);
		chk(n, 8'h40);
		on_backup_i <= 1'b1;
		count(8'h43, 512);
		chk(n, 8'h00);
		on_backup_i <= 1'b0;
		$display("test square done");
		wr(ADDR_OSCILLATOR_TRIM, 8'h80);
		count(8'h44, 16384);
		chk(n, 8'h04);
		wr(ADDR_OSCILLATOR_TRIM, 8'hFF);
		count(8'h44, 16384);
		chk({7'h00, n >= 8'h06}, 8'h01);
		wr(ADDR_OSCILLATOR_TRIM, 8'h7F);
		count(8'h44, 16384);
		chk({7'h00, n <= 8'h03}, 8'h01);
		$display("test trim done");
		report_and_stop();
	end
endmodule
`default_nettype wire
